// ==== test/host_mcu_model.sv ====
// host controller model issuing single-cycle register strobes
// assumes strobes launched on the falling edge of i_clk
`timescale 1ns/10ps
module host_mcu_model (
   // clock and read data
   input wire i_clk,
   input wire [7:0] i_rdata,
   // register strobes
   output reg o_wr_stb = 1'b0,
   output reg o_rd_stb = 1'b0,
   output reg [4:0] o_addr = 5'h00,
   output reg [7:0] o_wdata = 8'h00
);
   task xfer(input w, input [4:0] a, input [7:0] v);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = v;
      o_wr_stb = w;
      o_rd_stb = !w;
      @(negedge i_clk);
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b0;
      // released lines must not keep a stale value
      o_addr = ~a;
      o_wdata = ~v;
   endtask
   task wr(input [4:0] a, input [7:0] v);
      if ((a == 5'h09 || a == 5'h16) && v[6:3] == 4'h0) v[6:3] = 4'h1;
      xfer(1'b1, a, v);
   endtask
   task rd(input [4:0] a, output [7:0] v);
      xfer(1'b0, a, 8'h00);
      v = i_rdata;
   endtask
endmodule // host_mcu_model

// ==== test/rx_regs_checker.sv ====
// port assertions for the receiver register bank
// assumes clock enable held high and bank A active around checked writes
`timescale 1ns/10ps
module rx_regs_checker (
   input wire i_clk,
   input wire i_reset,
   input wire i_clk_en,
   input wire i_wr_stb,
   input wire i_rd_stb,
   input wire [4:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire i_ook_selected,
   input wire i_frequency_meaning,
   input wire [1:0] i_band_code,
   input wire o_if_gain_cut,
   input wire o_signal_strength_enable,
   input wire o_agc_force_max,
   input wire o_agc_hold,
   input wire o_bank_a_active,
   input wire [11:0] o_frequency_word,
   input wire o_add_if_offset,
   input wire o_half_ref_scale
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   wire wr_a = i_clk_en && i_wr_stb && o_bank_a_active;
   wire cmd_wr = wr_a && i_addr == 5'h03;
   a_signal_strength_result_enable: assert property (cmd_wr |-> ##2 o_signal_strength_enable == $past(i_wdata[4], 2))
      else $error("signal strength enable does not follow write");
   a_agc_force: assert property (cmd_wr |-> ##2 o_agc_force_max == $past(i_wdata[2], 2))
      else $error("agc force does not follow write");
   a_agc_freeze: assert property (cmd_wr && i_wdata[1] && !i_wdata[2] |-> ##2 o_agc_hold)
      else $error("agc hold missing after freeze write");
   a_gain_cut_fsk: assert property ((!i_ook_selected)[*3] |-> !o_if_gain_cut)
      else $error("gain cut active outside ook");
   a_direct_mode: assert property (i_frequency_meaning[*3] |-> !o_add_if_offset)
      else $error("offset added in direct mode");
   a_band_step: assert property ((i_band_code == 2'b11)[*3] |-> !o_half_ref_scale)
      else $error("half scale used for band 11");
   a_freq_low: assert property (wr_a && i_addr == 5'h05 |-> ##2
      o_frequency_word[7:0] == $past(i_wdata, 2))
      else $error("frequency low byte not applied");
   a_bank_flag: assert property (i_clk_en && i_rd_stb && i_addr == 5'h03 |=>
      o_rdata[0] == o_bank_a_active && !o_rdata[5])
      else $error("command readback flag or reserved bit wrong");
   c_cmd_write: cover property (cmd_wr);
   c_bank_b: cover property (!o_bank_a_active);
   c_signal_strength_result_read: cover property (i_rd_stb && i_addr == 5'h0c);
endmodule // rx_regs_checker

// ==== test/tb_top.sv ====
// self-checking bench for the receiver register bank
// assumes the host model drives strobes and the checker is bound in
`timescale 1ns/10ps
module tb_top;
   reg i_clk = 1'b0, i_reset = 1'b1, i_frequency_meaning = 1'b0;
   reg i_ook_selected = 1'b1, i_osc_started = 1'b0;
   reg [1:0] i_data_rate_field = 2'b01, i_average_filter_code = 2'b10, i_band_code = 2'b00;
   reg [3:0] i_lna_level = 4'h0, i_if_level = 4'h0;
   wire i_wr_stb, i_rd_stb;
   wire [4:0] i_addr;
   wire [7:0] i_wdata, o_rdata;
   logic [7:0] d;
   int errors = 0, tests_run = 0, n;
   int offn [8] = '{1, 2, 4, 8, 12, 16, 32, 63};
   int idn [4] = '{2, 4, 5, 6};
   int hdn [4] = '{1, 2, 4, 6};
   logic [12:0] rst_tbl [8] = '{13'h0309, 13'h0408, 13'h0500, 13'h097f, 13'h0ac0,
      13'h0b80, 13'h0c00, 13'h1a00};
   always #10 i_clk = ~i_clk;
   host_mcu_model host (.i_clk, .i_rdata(o_rdata), .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb),
      .o_addr(i_addr), .o_wdata(i_wdata));
   receiver_control_registers dut (.i_clk, .i_reset, .i_clk_en(1'b1), .i_wr_stb, .i_rd_stb,
      .i_addr, .i_wdata, .o_rdata, .i_data_rate_field, .i_average_filter_code, .i_band_code,
      .i_frequency_meaning, .i_ook_selected, .i_osc_started, .i_lna_level, .i_if_level,
      .o_avg_filter_sel(), .o_if_gain_cut(), .o_signal_strength_enable(),
      .o_envelope_decay_fast(), .o_agc_force_max(), .o_agc_hold(), .o_bank_a_active(),
      .o_frequency_word(), .o_add_if_offset(), .o_half_ref_scale(), .o_receiver_on(),
      .o_on_time_code(), .o_off_periods(), .o_identifier(), .o_identifier_len(), .o_header(),
      .o_header_len(), .o_signal_strength());
   task chk(input string s, input logic [11:0] e, input logic [11:0] v);
      tests_run++;
      if (v !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask
   task wt(input int c);
      repeat (c) @(negedge i_clk);
   endtask
   task t_reset;
      for (int k = 0; k < 8; k++) begin
         host.rd(rst_tbl[k][12:8], d);
         chk("reset read", 12'(rst_tbl[k][7:0]), 12'(d));
      end
      $display("end reset");
   endtask
   task t_cmd;
      host.wr(5'h03, 8'hff);
      host.rd(5'h03, d);
      chk("cmd read", 12'h0df, 12'(d));
      chk("avg sel", 12'h002, 12'(dut.o_avg_filter_sel));
      chk("gain cut", 12'h001, 12'(dut.o_if_gain_cut));
      chk("force", 12'h001, 12'(dut.o_agc_force_max));
      i_ook_selected = 1'b0;
      wt(4);
      chk("gain cut", 12'h000, 12'(dut.o_if_gain_cut));
      i_ook_selected = 1'b1;
      host.wr(5'h03, 8'h02);
      wt(2);
      chk("force", 12'h000, 12'(dut.o_agc_force_max));
      chk("hold", 12'h001, 12'(dut.o_agc_hold));
      chk("decay", 12'h000, 12'(dut.o_envelope_decay_fast));
      chk("avg sel", 12'h001, 12'(dut.o_avg_filter_sel));
      $display("end command");
   endtask
   task t_freq;
      host.wr(5'h04, 8'hfa);
      host.wr(5'h05, 8'h5c);
      host.rd(5'h04, d);
      chk("freq hi", 12'h00a, 12'(d));
      chk("freq word", 12'ha5c, dut.o_frequency_word);
      i_frequency_meaning = 1'b1;
      i_band_code = 2'b11;
      wt(4);
      chk("if offset", 12'h000, 12'(dut.o_add_if_offset));
      chk("half ref", 12'h000, 12'(dut.o_half_ref_scale));
      i_frequency_meaning = 1'b0;
      i_band_code = 2'b01;
      wt(4);
      chk("if offset", 12'h001, 12'(dut.o_add_if_offset));
      chk("half ref", 12'h001, 12'(dut.o_half_ref_scale));
      $display("end frequency");
   endtask
   task t_codes;
      for (int k = 0; k < 8; k++) begin
         host.wr(5'h09, {5'h01, 3'(k)});
         wt(2);
         chk("off periods", 12'(offn[k]), 12'(dut.o_off_periods));
      end
      for (int k = 0; k < 4; k++) begin
         host.wr(5'h0a, {2'(k), 6'h2a});
         host.wr(5'h0b, {2'(k), 6'h15});
         wt(2);
         chk("id len", 12'(idn[k]), 12'(dut.o_identifier_len));
         chk("hd len", 12'(hdn[k]), 12'(dut.o_header_len));
      end
      chk("id bits", 12'h02a, 12'(dut.o_identifier));
      chk("hd bits", 12'h015, 12'(dut.o_header));
      $display("end codes");
   endtask
   task t_signal_strength_result;
      i_lna_level = 4'ha;
      i_if_level = 4'h5;
      host.wr(5'h03, 8'h18);
      wt(6);
      chk("signal_strength_result out", 12'h0a5, 12'(dut.o_signal_strength));
      host.wr(5'h0c, 8'hff);
      host.rd(5'h0c, d);
      chk("signal_strength_result read", 12'h0a5, 12'(d));
      host.wr(5'h03, 8'h08);
      wt(4);
      i_lna_level = 4'h3;
      wt(6);
      chk("signal_strength_result frozen", 12'h0a5, 12'(dut.o_signal_strength));
      $display("end signal_strength_result");
   endtask
   task t_on_time;
      host.wr(5'h09, 8'h08);
      i_osc_started = 1'b1;
      n = 0;
      for (int k = 0; k < 20 && dut.o_receiver_on !== 1'b1; k++) wt(1);
      while (dut.o_receiver_on === 1'b1 && n < 600) begin
         n++;
         wt(1);
      end
      chk("on cycles", 12'h200, 12'(n));
      chk("on code", 12'h001, 12'(dut.o_on_time_code));
      i_osc_started = 1'b0;
      $display("end on time");
   endtask
   task t_bank;
      host.wr(5'h09, 8'h88);
      wt(2);
      chk("bank a", 12'h000, 12'(dut.o_bank_a_active));
      host.rd(5'h03, d);
      chk("flag a", 12'h000, 12'(d[0]));
      host.rd(5'h10, d);
      chk("flag b", 12'h000, 12'(d[0]));
      host.wr(5'h09, 8'h08);
      wt(2);
      chk("bank a", 12'h001, 12'(dut.o_bank_a_active));
      $display("end bank");
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      wt(2);
      i_reset = 1'b0;
      t_reset;
      t_cmd;
      t_freq;
      t_codes;
      t_signal_strength_result;
      t_on_time;
      t_bank;
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      errors++;
      stop_test;
   end
endmodule // tb_top
bind receiver_control_registers rx_regs_checker u_check (.i_clk, .i_reset, .i_clk_en,
   .i_wr_stb, .i_rd_stb, .i_addr, .i_wdata, .o_rdata, .i_ook_selected, .i_frequency_meaning,
   .i_band_code, .o_if_gain_cut, .o_signal_strength_enable, .o_agc_force_max, .o_agc_hold,
   .o_bank_a_active, .o_frequency_word, .o_add_if_offset, .o_half_ref_scale);

// ==== verilog/receiver_control_registers.v ====
// receiver register bank: command, frequency, duty cycle, id, header, signal_strength_result
// assumes the serial front end delivers single-cycle byte strobes on i_clk
`timescale 1ns/10ps
`include "rx_regs_consts.vh"
module receiver_control_registers (
   // clock and reset
   input wire i_clk,
   input wire i_reset,
   input wire i_clk_en,
   // register access from the serial front end
   input wire i_wr_stb,
   input wire i_rd_stb,
   input wire [`ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // configuration fields and oscillator status held outside this bank
   input wire [1:0] i_data_rate_field,
   input wire [1:0] i_average_filter_code,
   input wire [1:0] i_band_code,
   input wire i_frequency_meaning,
   input wire i_ook_selected,
   input wire i_osc_started,
   // converter results, asynchronous to i_clk
   input wire [3:0] i_lna_level,
   input wire [3:0] i_if_level,
   // control outputs
   output reg [1:0] o_avg_filter_sel,
   output reg o_if_gain_cut,
   output reg o_signal_strength_enable,
   output reg o_envelope_decay_fast,
   output reg o_agc_force_max,
   output reg o_agc_hold,
   output reg o_bank_a_active,
   output reg [11:0] o_frequency_word,
   output reg o_add_if_offset,
   output reg o_half_ref_scale,
   output reg o_receiver_on,
   output reg [3:0] o_on_time_code,
   output reg [5:0] o_off_periods,
   output reg [5:0] o_identifier,
   output reg [2:0] o_identifier_len,
   output reg [5:0] o_header,
   output reg [2:0] o_header_len,
   output reg [7:0] o_signal_strength
);
   // two banks, index 0 = bank a, 1 = bank b
   reg [7:0] command_r [0:1];
   reg [7:0] freq_hi_r [0:1];
   reg [7:0] freq_lo_r [0:1];
   reg [7:0] duty_r [0:1];
   reg [7:0] ident_r [0:1];
   reg [7:0] header_r [0:1];
   reg [3:0] lna_meta_r, lna_sync_r, if_meta_r, if_sync_r;
   reg osc_meta_r, osc_sync_r;
   reg [7:0] signal_strength_result_r;
   reg [12:0] on_cnt_r;
   reg [3:0] on_units_r;
   reg bank_r;
   wire [5:0] off_dec;
   wire [2:0] id_len_dec, hd_len_dec;
   wire act;

   // returns bank index and local offset for an absolute register address
   function [5:0] decode_addr;
      input [`ADDR_W-1:0] a;
      begin
         if (a >= `BANK_B_OFFSET)
            decode_addr = {1'b1, a - `BANK_B_OFFSET};
         else
            decode_addr = {1'b0, a};
      end
   endfunction

   wire [5:0] dec = decode_addr(i_addr);
   wire bsel = dec[5];
   wire [`ADDR_W-1:0] loc = dec[4:0];

   // bank in use: bank a while its duty bit is clear, so reset starts in bank a
   always @* bank_r = duty_r[0][`DUTY_BANK_SEL];
   assign act = bank_r;

   // register writes; bank b command keeps own copy except read-only bits
   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_bank
         always @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               command_r[b] <= `RST_COMMAND;
               freq_hi_r[b] <= `RST_FREQ_HI;
               freq_lo_r[b] <= `RST_FREQ_LO;
               duty_r[b] <= `RST_DUTY;
               ident_r[b] <= `RST_IDENT;
               header_r[b] <= `RST_HEADER;
            end else if (i_clk_en && i_wr_stb && bsel == b) begin
               case (loc)
                  `ADDR_COMMAND: command_r[b] <= (i_wdata & `CMD_WMASK) |
                     (command_r[b] & ~`CMD_WMASK);
                  `ADDR_FREQ_HI: freq_hi_r[b] <= i_wdata & `FREQ_HI_WMASK;
                  `ADDR_FREQ_LO: freq_lo_r[b] <= i_wdata;
                  `ADDR_DUTY: duty_r[b] <= i_wdata;
                  `ADDR_IDENT: ident_r[b] <= i_wdata;
                  `ADDR_HEADER: header_r[b] <= i_wdata;
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   // converter levels and oscillator status come from another domain
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         lna_meta_r <= 4'h0;
         lna_sync_r <= 4'h0;
         if_meta_r <= 4'h0;
         if_sync_r <= 4'h0;
         osc_meta_r <= 1'b0;
         osc_sync_r <= 1'b0;
         signal_strength_result_r <= 8'h00;
      end else if (i_clk_en) begin
         lna_meta_r <= i_lna_level;
         lna_sync_r <= lna_meta_r;
         if_meta_r <= i_if_level;
         if_sync_r <= if_meta_r;
         osc_meta_r <= i_osc_started;
         osc_sync_r <= osc_meta_r;
         // result freezes while measurement is disabled
         if (command_r[act][`CMD_SIGNAL_STRENGTH_RESULT_EN]) begin
            signal_strength_result_r <= {lna_sync_r, if_sync_r};
         end
      end
   end

   // on-time counter: n units of 512 clocks after oscillator start
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         on_cnt_r <= 13'h0000;
         on_units_r <= 4'h0;
         o_receiver_on <= 1'b0;
      end else if (i_clk_en) begin
         if (!osc_sync_r) begin
            on_cnt_r <= 13'h0000;
            on_units_r <= 4'h0;
            o_receiver_on <= 1'b0;
         end else if (on_units_r < duty_r[act][6:3]) begin
            o_receiver_on <= 1'b1;
            if (on_cnt_r == `ON_TIME_UNIT - 13'h0001) begin
               on_cnt_r <= 13'h0000;
               on_units_r <= on_units_r + 4'h1;
            end else begin
               on_cnt_r <= on_cnt_r + 13'h0001;
            end
         end else begin
            // code 0 is forbidden; it simply keeps the receiver off
            o_receiver_on <= 1'b0;
         end
      end
   end

   strobe_code_decode u_dec (
      .i_off_code(duty_r[act][2:0]),
      .i_id_len_code(ident_r[act][7:6]),
      .i_hd_len_code(header_r[act][7:6]),
      .o_off_periods(off_dec),
      .o_id_len(id_len_dec),
      .o_hd_len(hd_len_dec)
   );

   // registered control outputs from the active bank and the configuration inputs
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_avg_filter_sel <= 2'h0;
         o_if_gain_cut <= 1'b0;
         o_signal_strength_enable <= 1'b0;
         o_envelope_decay_fast <= 1'b1;
         o_agc_force_max <= 1'b0;
         o_agc_hold <= 1'b0;
         o_bank_a_active <= 1'b1;
         o_frequency_word <= 12'h800;
         o_add_if_offset <= 1'b1;
         o_half_ref_scale <= 1'b1;
         o_on_time_code <= 4'hf;
         o_off_periods <= 6'h3f;
         o_identifier <= 6'h00;
         o_identifier_len <= 3'h6;
         o_header <= 6'h00;
         o_header_len <= 3'h4;
         o_signal_strength <= 8'h00;
      end else if (i_clk_en) begin
         o_avg_filter_sel <= command_r[act][`CMD_AVG_OVR] ?
            i_average_filter_code : i_data_rate_field;
         o_if_gain_cut <= command_r[act][`CMD_IF_CUT] & i_ook_selected;
         o_signal_strength_enable <= command_r[act][`CMD_SIGNAL_STRENGTH_RESULT_EN];
         o_envelope_decay_fast <= command_r[act][`CMD_DECAY];
         o_agc_force_max <= command_r[act][`CMD_AGC_RST];
         // a forced reset overrides a freeze
         o_agc_hold <= command_r[act][`CMD_AGC_FRZ] &
            ~command_r[act][`CMD_AGC_RST];
         o_bank_a_active <= act == 1'b0;
         o_frequency_word <= {freq_hi_r[act][3:0], freq_lo_r[act]};
         o_add_if_offset <= ~i_frequency_meaning;
         o_half_ref_scale <= ~(i_band_code[1] & i_band_code[0]);
         o_on_time_code <= duty_r[act][6:3];
         o_off_periods <= off_dec;
         o_identifier <= ident_r[act][5:0];
         o_identifier_len <= id_len_dec;
         o_header <= header_r[act][5:0];
         o_header_len <= hd_len_dec;
         o_signal_strength <= signal_strength_result_r;
      end
   end

   // read data, captured on the read strobe
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_clk_en && i_rd_stb) begin
         case (loc)
            // reserved bit forced low, bank flag shared by both banks
            `ADDR_COMMAND: o_rdata <= {command_r[bsel][7:6], 1'b0,
               command_r[bsel][4:1], ~act};
            `ADDR_FREQ_HI: o_rdata <= {4'h0, freq_hi_r[bsel][3:0]};
            `ADDR_FREQ_LO: o_rdata <= freq_lo_r[bsel];
            `ADDR_DUTY: o_rdata <= duty_r[bsel];
            `ADDR_IDENT: o_rdata <= ident_r[bsel];
            `ADDR_HEADER: o_rdata <= header_r[bsel];
            `ADDR_SIGNAL_STRENGTH_RESULT: o_rdata <= signal_strength_result_r;
            default: o_rdata <= 8'h00;
         endcase
      end
   end
endmodule // receiver_control_registers

// ==== verilog/rx_regs_consts.vh ====
// register bank constants: offsets, fields, reset values, timing
// assumes byte-wide register access with a 5-bit address space
`ifndef RX_REGS_CONSTS_VH
`define RX_REGS_CONSTS_VH

`define ADDR_W 5
`define ADDR_COMMAND 5'h03
`define ADDR_FREQ_HI 5'h04
`define ADDR_FREQ_LO 5'h05
`define ADDR_DUTY 5'h09
`define ADDR_IDENT 5'h0a
`define ADDR_HEADER 5'h0b
`define ADDR_SIGNAL_STRENGTH_RESULT 5'h0c
`define BANK_B_OFFSET 5'h0d

`define RST_COMMAND 8'h09
`define RST_FREQ_HI 8'h48
`define RST_FREQ_LO 8'h00
`define RST_DUTY 8'h7f
`define RST_IDENT 8'hc0
`define RST_HEADER 8'h80

// writable mask of the command byte: bit 5 reserved, bit 0 read-only
`define CMD_WMASK 8'hde
`define FREQ_HI_WMASK 8'h0f

`define CMD_AVG_OVR 7
`define CMD_IF_CUT 6
`define CMD_SIGNAL_STRENGTH_RESULT_EN 4
`define CMD_DECAY 3
`define CMD_AGC_RST 2
`define CMD_AGC_FRZ 1
`define CMD_BANK_FLAG 0
`define DUTY_BANK_SEL 7

// on-time unit, in digital clock periods
`define ON_TIME_UNIT 13'h0200

`endif

// ==== verilog/strobe_code_decode.v ====
// decoder for the duty-cycle, identifier and header length codes
// assumes purely combinational use inside the register bank
`timescale 1ns/10ps
module strobe_code_decode (
   // codes
   input wire [2:0] i_off_code,
   input wire [1:0] i_id_len_code,
   input wire [1:0] i_hd_len_code,
   // decoded counts
   output reg [5:0] o_off_periods,
   output reg [2:0] o_id_len,
   output reg [2:0] o_hd_len
);
   always @* begin
      case (i_off_code)
         3'h0: o_off_periods = 6'h01;
         3'h1: o_off_periods = 6'h02;
         3'h2: o_off_periods = 6'h04;
         3'h3: o_off_periods = 6'h08;
         3'h4: o_off_periods = 6'h0c;
         3'h5: o_off_periods = 6'h10;
         3'h6: o_off_periods = 6'h20;
         default: o_off_periods = 6'h3f;
      endcase
      case (i_id_len_code)
         2'h0: o_id_len = 3'h2;
         2'h1: o_id_len = 3'h4;
         2'h2: o_id_len = 3'h5;
         default: o_id_len = 3'h6;
      endcase
      case (i_hd_len_code)
         2'h0: o_hd_len = 3'h1;
         2'h1: o_hd_len = 3'h2;
         2'h2: o_hd_len = 3'h4;
         default: o_hd_len = 3'h6;
      endcase
   end
endmodule // strobe_code_decode
